// *** core/mdh_pkg.sv ***
package mdh_pkg;
  // descriptor word offsets from the descriptor start
  localparam logic [31:0] OFS_W0 = 32'h0000_0000;
  localparam logic [31:0] OFS_W1 = 32'h0000_0004;
  localparam logic [31:0] OFS_W2 = 32'h0000_0008;
  localparam logic [31:0] OFS_W3 = 32'h0000_000C;
  localparam logic [31:0] WORD_STEP = 32'h0000_0004;
  // send descriptor word 0
  localparam int unsigned OWN_BIT = 31;
  localparam int unsigned IRQ_BIT = 2;
  localparam int unsigned FCS_BIT = 1;
  localparam int unsigned PAD_BIT = 0;
  // send descriptor word 2 (status and length)
  localparam int unsigned TALLY_LSB = 28;
  localparam int unsigned HB_BIT = 26;
  localparam int unsigned PAUSE_BIT = 25;
  localparam int unsigned STOP_BIT = 24;
  localparam int unsigned LATE_BIT = 23;
  localparam int unsigned GIVEUP_BIT = 22;
  localparam int unsigned NOCAR_BIT = 21;
  localparam int unsigned EXCESS_BIT = 20;
  localparam int unsigned DONE_BIT = 19;
  localparam int unsigned WAITED_BIT = 17;
  localparam int unsigned SIRQ_BIT = 16;
  localparam int unsigned LEN_W = 16;
  localparam int unsigned TALLY_W = 4;
  localparam logic [3:0] TALLY_MAX = 4'hF;
  localparam logic [15:0] MIN_FRAME = 16'h003C;
  localparam logic [15:0] LAST_PAD = 16'h003B;
  localparam logic [15:0] LATE_WINDOW = 16'h0040;
  // staging buffer in front of the mac
  localparam int unsigned FIFO_WIDTH = 9;
  localparam int unsigned FIFO_DEPTH = 8;
  // deferral limits
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned DEFER_100_NS = 327680;
  localparam int unsigned DEFER_10_NS = 3276800;
  localparam int unsigned DEFER_100_CYC = DEFER_100_NS / CLK_PERIOD_NS;
  localparam int unsigned DEFER_10_CYC = DEFER_10_NS / CLK_PERIOD_NS;
  localparam int unsigned DCNT_W = 17;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_RD_W0 = 4'h1,
    ST_RD_W1 = 4'h2,
    ST_RD_W2 = 4'h3,
    ST_RD_DATA = 4'h4,
    ST_UNPACK = 4'h5,
    ST_PAD = 4'h6,
    ST_WAIT_END = 4'h7,
    ST_STATUS = 4'h8,
    ST_WR_W2 = 4'h9,
    ST_WR_W0 = 4'hA,
    ST_RD_W3 = 4'hB,
    ST_RX_W3 = 4'hC
  } mdh_state_t;
endpackage : mdh_pkg

// *** core/mdh_fifo.sv ***
`timescale 1ns/10ps
module mdh_fifo #(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned DEPTH = 8
) (
  input logic clk_i,
  input logic nrst_i,
  input logic flush_i,
  input logic in_valid_i,
  output logic in_ready_o,
  input logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int unsigned AW = $clog2(DEPTH);
  localparam int unsigned CW = AW + 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [CW-1:0] cnt;
    logic ov;
    logic [WIDTH-1:0] od;
  } mdh_fifo_st_t;

  mdh_fifo_st_t s;
  mdh_fifo_st_t n;
  logic take;
  logic load;

  // output word is registered so the mac sees flop-driven data
  always_comb begin
    n = s;
    in_ready_o = (s.cnt < CW'(DEPTH));
    take = in_valid_i && in_ready_o;
    load = (s.cnt != '0) && (!s.ov || out_ready_i);
    if (out_ready_i && s.ov) begin
      n.ov = 1'b0;
    end
    if (load) begin
      n.od = s.mem[s.rp];
      n.ov = 1'b1;
      n.rp = s.rp + 1'b1;
    end
    if (take) begin
      n.mem[s.wp] = in_data_i;
      n.wp = s.wp + 1'b1;
    end
    n.cnt = s.cnt + CW'(take) - CW'(load);
    if (flush_i) begin
      n = '0;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign out_valid_o = s.ov;
  assign out_data_o = s.od;
endmodule : mdh_fifo

// *** core/mdh_status.sv ***
`timescale 1ns/10ps
module mdh_status
  import mdh_pkg::*;
#(
  parameter int unsigned DEFER_100 = DEFER_100_CYC,
  parameter int unsigned DEFER_10 = DEFER_10_CYC
) (
  input logic clk_i,
  input logic nrst_i,
  input logic clr_i,
  input logic half_duplex_i,
  input logic speed_10_i,
  input logic heartbeat_check_on_i,
  input logic no_wait_limit_i,
  input logic col_i,
  input logic defer_i,
  input logic sqe_err_i,
  input logic end_i,
  input logic active_i,
  input logic past_window_i,
  input logic mii_crs_i,
  output logic [3:0] collision_tally_o,
  output logic send_given_up_o,
  output logic late_clash_o,
  output logic no_carrier_seen_o,
  output logic excess_wait_flag_o,
  output logic waited_before_send_o,
  output logic heartbeat_err_o
);
  typedef struct packed {
    logic [2:0] sync;
    logic crs;
    logic seen;
    logic [3:0] tally;
    logic give_up;
    logic late;
    logic nocar;
    logic excess;
    logic waited;
    logic hb;
    logic [DCNT_W-1:0] dcnt;
  } mdh_stat_st_t;

  mdh_stat_st_t s;
  mdh_stat_st_t n;
  logic [DCNT_W-1:0] limit;

  always_comb begin
    n = s;
    limit = speed_10_i ? DCNT_W'(DEFER_10) : DCNT_W'(DEFER_100);
    // carrier is a pin: stage 2 and 3 must agree before it counts
    n.sync = {s.sync[1], s.sync[0], mii_crs_i};
    if (s.sync[1] == s.sync[2]) begin
      n.crs = s.sync[2];
    end
    if (clr_i) begin
      n.seen = 1'b0;
      n.tally = '0;
      n.give_up = 1'b0;
      n.late = 1'b0;
      n.nocar = 1'b0;
      n.excess = 1'b0;
      n.waited = 1'b0;
      n.hb = 1'b0;
      n.dcnt = '0;
    end
    // set wins: an event in the clearing cycle still counts
    if (half_duplex_i) begin
      if (col_i) begin
        if (past_window_i) begin
          n.late = 1'b1;
        end
        if (n.tally == TALLY_MAX) begin
          n.tally = '0;
          n.give_up = 1'b1;
        end else begin
          n.tally = n.tally + 4'h1;
        end
      end
      if (defer_i) begin
        n.waited = 1'b1;
        if (!no_wait_limit_i && (n.dcnt >= limit)) begin
          n.excess = 1'b1;
        end
        if (n.dcnt != '1) begin
          n.dcnt = n.dcnt + 1'b1;
        end
      end
      if (active_i && s.crs) begin
        n.seen = 1'b1;
      end else if (active_i && n.seen) begin
        n.nocar = 1'b1;
      end
      if (end_i && !n.seen && !s.crs) begin
        n.nocar = 1'b1;
      end
      if (end_i && sqe_err_i && heartbeat_check_on_i && speed_10_i) begin
        n.hb = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign collision_tally_o = s.tally;
  assign send_given_up_o = s.give_up;
  assign late_clash_o = s.late;
  assign no_carrier_seen_o = s.nocar;
  assign excess_wait_flag_o = s.excess;
  assign waited_before_send_o = s.waited;
  assign heartbeat_err_o = s.hb;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);

  a_tally_wrap_abort: assert property (
    half_duplex_i && col_i && !clr_i && s.tally == TALLY_MAX |=> s.tally == '0 && s.give_up)
    else $error("tally did not wrap with abort");
  a_give_up_half: assert property (
    $rose(s.give_up) |-> $past(half_duplex_i && col_i))
    else $error("abort without half duplex collision");
  a_heartbeat_gate: assert property (
    $rose(s.hb) |-> $past(heartbeat_check_on_i && half_duplex_i && speed_10_i && end_i))
    else $error("heartbeat error outside its mode");
  a_late_window: assert property (
    $rose(s.late) |-> $past(col_i && past_window_i && half_duplex_i))
    else $error("late collision flagged without cause");
  a_excess_gate: assert property (
    $rose(s.excess) |-> $past(!no_wait_limit_i && half_duplex_i && defer_i))
    else $error("deferral excess flagged without cause");
  a_wait_flag_set: assert property (
    half_duplex_i && defer_i && !clr_i |=> s.waited)
    else $error("deferral not recorded");
  a_nocar_half: assert property (
    $rose(s.nocar) |-> $past(half_duplex_i))
    else $error("carrier loss flagged in full duplex");
endmodule : mdh_status

// *** core/mdh_desc_dma.sv ***
`timescale 1ns/10ps
// Summary of operation
// - receive word two is never fetched; its content means nothing.
// - next receive descriptor comes from word three, low two bits dropped.
// - owner bit 31 of word 0; one means the mac holds it.
// - after a frame the owner bit is written back as zero.
// - done pulse raised only when word 0 bit 2 is set.
// - word 0 bit 1 asks the mac to append the 4-byte fcs.
// - word 0 bit 0 pads frames shorter than 60 bytes.
// - word 1 bits 31:2 give the word aligned buffer base.
// - word 1 bits 1:0 give the first byte lane in the buffer.
// - word 2 bits 31:28 hold collisions, wrapping to zero at 16.
// - sixteen collisions in half duplex abandon the frame, bit 22.
// - heartbeat error bit 26 checked only when enabled at 10M half.
// - bit 25 set when flow control will pause the next send.
// - bit 24 set when software cleared the send run control.
// - bit 23 set for a collision after 64 bytes, half duplex.
// - bit 21 set when carrier never rises or drops, half duplex.
// - bit 20 set when deferral exceeds its speed limit.
// - bit 19 set when the mac ended the frame and it was not abandoned.
// - bit 17 set when the frame deferred at least once.
// - bit 16 records that word 0 bit 2 asked for the done pulse.
module mdh_desc_dma
  import mdh_pkg::*;
#(
  parameter int unsigned DEFER_100 = DEFER_100_CYC,
  parameter int unsigned DEFER_10 = DEFER_10_CYC
) (
  input logic clk_i,
  input logic nrst_i,
  input logic tx_kick_i,
  input logic [31:0] tx_list_base_i,
  input logic rx_next_i,
  input logic [31:0] rx_list_base_i,
  input logic send_run_i,
  input logic send_flow_pause_i,
  input logic flow_frame_rx_i,
  input logic half_duplex_i,
  input logic speed_10_i,
  input logic heartbeat_check_on_i,
  input logic no_wait_limit_i,
  output logic mem_req_o,
  output logic mem_we_o,
  output logic [31:0] mem_addr_o,
  output logic [31:0] mem_wdata_o,
  input logic mem_ack_i,
  input logic [31:0] mem_rdata_i,
  output logic [7:0] tx_data_o,
  output logic tx_last_o,
  output logic tx_valid_o,
  input logic tx_ready_i,
  output logic append_fcs_o,
  input logic mac_col_i,
  input logic mac_defer_i,
  input logic mac_sqe_err_i,
  input logic mac_end_i,
  input logic mii_crs_i,
  output logic send_irq_o,
  output logic tx_busy_o,
  output logic [31:0] rx_desc_addr_o,
  output logic rx_link_valid_o
);
  typedef struct packed {
    mdh_state_t st;
    logic req;
    logic we;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [31:0] cur;
    logic based;
    logic kick;
    logic [31:0] w0;
    logic [31:0] w1;
    logic [15:0] len;
    logic [31:0] dbuf;
    logic [1:0] lane;
    logic [15:0] rem;
    logic [15:0] fl;
    logic [15:0] sent;
    logic on_wire;
    logic ok;
    logic fcs;
    logic irq;
    logic clr;
    logic busy;
    logic [31:0] rxcur;
    logic rxbased;
    logic rxpend;
    logic rxv;
  } mdh_dma_st_t;

  mdh_dma_st_t s;
  mdh_dma_st_t n;
  logic ack;
  logic push;
  logic [8:0] push_data;
  logic in_ready;
  logic flush;
  logic pop;
  logic pad_more;
  logic abort;
  logic [31:0] stw;
  logic [3:0] tally;
  logic give_up;
  logic late;
  logic nocar;
  logic excess;
  logic waited;
  logic hb;
  logic [8:0] fifo_out;

  always_comb begin
    n = s;
    n.clr = 1'b0;
    n.irq = 1'b0;
    push = 1'b0;
    push_data = '0;
    flush = 1'b0;
    stw = '0;
    ack = s.req && mem_ack_i;
    pop = tx_valid_o && tx_ready_i;
    abort = give_up && !s.req;
    pad_more = s.w0[PAD_BIT] && ((s.fl + 16'h0001) < MIN_FRAME);
    if (ack) begin
      n.req = 1'b0;
    end
    if (pop) begin
      n.sent = s.sent + 16'h0001;
      n.on_wire = 1'b1;
    end
    if (mac_col_i) begin
      n.sent = '0;
    end
    case (s.st)
      ST_IDLE: begin
        if (s.rxpend) begin
          n.st = ST_RX_W3;
          n.req = 1'b1;
          n.we = 1'b0;
          n.addr = s.rxcur + OFS_W3;
        end else if (s.kick && send_run_i) begin
          n.kick = 1'b0;
          n.based = 1'b1;
          n.cur = s.based ? s.cur : {tx_list_base_i[31:2], 2'b00};
          n.st = ST_RD_W0;
          n.req = 1'b1;
          n.we = 1'b0;
          n.addr = n.cur + OFS_W0;
        end
      end
      ST_RX_W3: begin
        if (ack) begin
          n.rxcur = {mem_rdata_i[31:2], 2'b00};
          n.rxv = 1'b1;
          n.rxpend = 1'b0;
          n.st = ST_IDLE;
        end
      end
      ST_RD_W0: begin
        if (ack) begin
          n.w0 = mem_rdata_i;
          if (!mem_rdata_i[OWN_BIT]) begin
            n.st = ST_IDLE;
          end else begin
            n.fcs = mem_rdata_i[FCS_BIT];
            n.st = ST_RD_W1;
            n.req = 1'b1;
            n.addr = s.cur + OFS_W1;
          end
        end
      end
      ST_RD_W1: begin
        if (ack) begin
          n.w1 = mem_rdata_i;
          n.st = ST_RD_W2;
          n.req = 1'b1;
          n.addr = s.cur + OFS_W2;
        end
      end
      ST_RD_W2: begin
        if (ack) begin
          n.len = mem_rdata_i[LEN_W-1:0];
          n.rem = mem_rdata_i[LEN_W-1:0];
          n.fl = '0;
          n.sent = '0;
          n.on_wire = 1'b0;
          n.ok = 1'b0;
          n.clr = 1'b1;
          n.lane = s.w1[1:0];
          n.addr = {s.w1[31:2], 2'b00};
          if (mem_rdata_i[LEN_W-1:0] != '0) begin
            n.st = ST_RD_DATA;
            n.req = 1'b1;
          end else begin
            n.st = s.w0[PAD_BIT] ? ST_PAD : ST_WAIT_END;
          end
        end
      end
      ST_RD_DATA: begin
        if (abort) begin
          flush = 1'b1;
          n.st = ST_STATUS;
        end else if (ack) begin
          n.dbuf = mem_rdata_i;
          n.st = ST_UNPACK;
        end
      end
      ST_UNPACK: begin
        if (abort) begin
          flush = 1'b1;
          n.st = ST_STATUS;
        end else begin
          push = 1'b1;
          push_data = {(s.rem == 16'h0001) && !pad_more, s.dbuf[{s.lane, 3'b000} +: 8]};
          if (in_ready) begin
            n.rem = s.rem - 16'h0001;
            n.fl = s.fl + 16'h0001;
            if (s.rem == 16'h0001) begin
              n.st = pad_more ? ST_PAD : ST_WAIT_END;
            end else if (s.lane == 2'b11) begin
              n.lane = 2'b00;
              n.addr = s.addr + WORD_STEP;
              n.req = 1'b1;
              n.st = ST_RD_DATA;
            end else begin
              n.lane = s.lane + 2'b01;
            end
          end
        end
      end
      ST_PAD: begin
        if (abort) begin
          flush = 1'b1;
          n.st = ST_STATUS;
        end else begin
          push = 1'b1;
          push_data = {s.fl == LAST_PAD, 8'h00};
          if (in_ready) begin
            n.fl = s.fl + 16'h0001;
            if (s.fl == LAST_PAD) begin
              n.st = ST_WAIT_END;
            end
          end
        end
      end
      ST_WAIT_END: begin
        if (abort) begin
          flush = 1'b1;
          n.st = ST_STATUS;
        end else if (mac_end_i) begin
          n.ok = 1'b1;
          n.st = ST_STATUS;
        end
      end
      ST_STATUS: begin
        // one cycle late so end-of-frame flags have settled
        stw[LEN_W-1:0] = s.len;
        stw[TALLY_LSB +: TALLY_W] = tally;
        stw[HB_BIT] = hb;
        stw[PAUSE_BIT] = send_flow_pause_i || flow_frame_rx_i;
        stw[STOP_BIT] = !send_run_i;
        stw[LATE_BIT] = late;
        stw[GIVEUP_BIT] = give_up;
        stw[NOCAR_BIT] = nocar;
        stw[EXCESS_BIT] = excess;
        stw[DONE_BIT] = s.ok && !give_up;
        stw[WAITED_BIT] = waited;
        stw[SIRQ_BIT] = s.w0[IRQ_BIT];
        n.on_wire = 1'b0;
        n.wdata = stw;
        n.req = 1'b1;
        n.we = 1'b1;
        n.addr = s.cur + OFS_W2;
        n.st = ST_WR_W2;
      end
      ST_WR_W2: begin
        if (ack) begin
          n.wdata = {1'b0, s.w0[OWN_BIT-1:0]};
          n.req = 1'b1;
          n.addr = s.cur + OFS_W0;
          n.st = ST_WR_W0;
        end
      end
      ST_WR_W0: begin
        if (ack) begin
          n.irq = s.w0[IRQ_BIT];
          n.we = 1'b0;
          if (!send_run_i) begin
            n.st = ST_IDLE;
          end else begin
            n.req = 1'b1;
            n.addr = s.cur + OFS_W3;
            n.st = ST_RD_W3;
          end
        end
      end
      ST_RD_W3: begin
        if (ack) begin
          n.cur = {mem_rdata_i[31:2], 2'b00};
          n.req = 1'b1;
          n.addr = {mem_rdata_i[31:2], 2'b00} + OFS_W0;
          n.st = ST_RD_W0;
        end
      end
      default: begin
        n.st = ST_IDLE;
        n.req = 1'b0;
      end
    endcase
    // requests arriving with a clear still count
    if (tx_kick_i) begin
      n.kick = 1'b1;
    end
    if (rx_next_i) begin
      if (!s.rxbased) begin
        n.rxbased = 1'b1;
        n.rxcur = {rx_list_base_i[31:2], 2'b00};
        n.rxv = 1'b1;
      end else begin
        n.rxpend = 1'b1;
      end
    end
    n.busy = (n.st != ST_IDLE);
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  // small buffer: retries must be replayed by the mac itself
  mdh_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .flush_i(flush),
    .in_valid_i(push),
    .in_ready_o(in_ready),
    .in_data_i(push_data),
    .out_valid_o(tx_valid_o),
    .out_ready_i(tx_ready_i),
    .out_data_o(fifo_out)
  );

  mdh_status #(
    .DEFER_100(DEFER_100),
    .DEFER_10(DEFER_10)
  ) u_status (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .clr_i(s.clr),
    .half_duplex_i(half_duplex_i),
    .speed_10_i(speed_10_i),
    .heartbeat_check_on_i(heartbeat_check_on_i),
    .no_wait_limit_i(no_wait_limit_i),
    .col_i(mac_col_i),
    .defer_i(mac_defer_i),
    .sqe_err_i(mac_sqe_err_i),
    .end_i(mac_end_i),
    .active_i(s.on_wire),
    .past_window_i(s.sent >= LATE_WINDOW),
    .mii_crs_i(mii_crs_i),
    .collision_tally_o(tally),
    .send_given_up_o(give_up),
    .late_clash_o(late),
    .no_carrier_seen_o(nocar),
    .excess_wait_flag_o(excess),
    .waited_before_send_o(waited),
    .heartbeat_err_o(hb)
  );

  assign tx_data_o = fifo_out[7:0];
  assign tx_last_o = fifo_out[8];
  assign mem_req_o = s.req;
  assign mem_we_o = s.we;
  assign mem_addr_o = s.addr;
  assign mem_wdata_o = s.wdata;
  assign append_fcs_o = s.fcs;
  assign send_irq_o = s.irq;
  assign tx_busy_o = s.busy;
  assign rx_desc_addr_o = s.rxcur;
  assign rx_link_valid_o = s.rxv;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);

  a_owner_clear: assert property (
    s.st == ST_WR_W0 && s.req |-> !s.wdata[OWN_BIT] && s.we && s.addr == s.cur + OFS_W0)
    else $error("owner word not handed back");
  a_status_first: assert property (
    $rose(s.st == ST_WR_W0) |-> $past(s.st) == ST_WR_W2)
    else $error("owner written before status");
  a_irq_gate: assert property (
    s.irq |-> s.w0[IRQ_BIT] && $past(s.st) == ST_WR_W0)
    else $error("done pulse without enable");
  a_link_align: assert property (
    s.req && s.st inside {ST_RD_W0, ST_RX_W3} |-> s.addr[1:0] == 2'b00 && s.rxcur[1:0] == 2'b00)
    else $error("descriptor address not aligned");
  a_buf_offset: assert property (
    s.st == ST_RD_W2 && ack && mem_rdata_i[LEN_W-1:0] != '0
      |=> s.lane == s.w1[1:0] && s.addr == {s.w1[31:2], 2'b00})
    else $error("buffer start wrong");
  a_fcs_flag: assert property (
    s.st == ST_UNPACK |-> s.fcs == s.w0[FCS_BIT])
    else $error("fcs request not following descriptor");
  a_pad_limit: assert property (
    s.st == ST_PAD |-> s.w0[PAD_BIT] && s.fl < MIN_FRAME)
    else $error("padding beyond minimum length");
  a_chain_stop: assert property (
    s.st == ST_RD_W0 && ack && !mem_rdata_i[OWN_BIT] |=> s.st == ST_IDLE && !s.req && !s.busy)
    else $error("cpu owned descriptor processed");
  a_done_bit: assert property (
    s.st == ST_WR_W2 && s.req |-> !(s.wdata[DONE_BIT] && s.wdata[GIVEUP_BIT]))
    else $error("aborted frame marked done");
  c_frame_done: cover property (s.st == ST_WR_W0 && ack && s.w0[IRQ_BIT]);
  c_abort: cover property (s.st == ST_STATUS && give_up);
  c_padded: cover property (s.st == ST_PAD ##1 s.st == ST_WAIT_END);
  c_rx_link: cover property (s.st == ST_RX_W3 && ack);
endmodule : mdh_desc_dma

// *** verification/mdh_mem_model.sv ***
`timescale 1ns/10ps
module mdh_mem_model (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic req_i,
  input wire logic we_i,
  input wire logic [31:0] addr_i,
  input wire logic [31:0] wdata_i,
  output logic ack_o,
  output logic [31:0] rdata_o
);
  logic [31:0] mem [0:255];
  logic [31:0] lf;
  // random stalls, same-cycle answers too
  assign ack_o = req_i && lf[0];
  assign rdata_o = ack_o ? mem[addr_i[9:2]] : ~lf;
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      lf <= 32'h0000_1234;
    end else begin
      lf <= {lf[30:0], lf[31] ^ lf[21] ^ lf[1]};
      if (ack_o && we_i) begin
        mem[addr_i[9:2]] <= wdata_i;
      end
    end
  end
endmodule : mdh_mem_model

// *** verification/mac_descriptor_handling_tb.sv ***
`timescale 1ns/10ps
module mac_descriptor_handling_tb;
  import mdh_pkg::*;
  logic clk_i = 0, nrst_i = 0, kick = 0, rxn = 0, rdy = 0, col = 0, mend = 0, hd = 0;
  logic run = 1, sfp = 0, ffr = 0, s10 = 0, hbc = 0, nwl = 0, dfr = 0, heartbeat_err = 0, crs = 1;
  logic [31:0] tb_base = 32'h0000_0100, rb = 32'h0000_0300, seed = 32'h0000_30a9;
  logic req, we, ack, txl, txv, fcs, irq, busy, rxv;
  logic [31:0] addr, wd, rd, rxa;
  logic [7:0] txd;
  int n_fail = 0, n_tests = 0, irqs = 0;
  always #20 clk_i = ~clk_i;
  always @(negedge clk_i) if (irq === 1'b1) irqs++;
  mdh_mem_model mem_u (.clk_i(clk_i), .nrst_i(nrst_i), .req_i(req), .we_i(we),
    .addr_i(addr), .wdata_i(wd), .ack_o(ack), .rdata_o(rd));
  mdh_desc_dma #(.DEFER_100(20), .DEFER_10(50)) dut_u (.clk_i(clk_i), .nrst_i(nrst_i),
    .tx_kick_i(kick), .tx_list_base_i(tb_base), .rx_next_i(rxn), .rx_list_base_i(rb),
    .send_run_i(run), .send_flow_pause_i(sfp), .flow_frame_rx_i(ffr), .half_duplex_i(hd),
    .speed_10_i(s10), .heartbeat_check_on_i(hbc), .no_wait_limit_i(nwl), .mem_req_o(req),
    .mem_we_o(we), .mem_addr_o(addr), .mem_wdata_o(wd), .mem_ack_i(ack), .mem_rdata_i(rd),
    .tx_data_o(txd), .tx_last_o(txl), .tx_valid_o(txv), .tx_ready_i(rdy),
    .append_fcs_o(fcs), .mac_col_i(col), .mac_defer_i(dfr), .mac_sqe_err_i(heartbeat_err),
    .mac_end_i(mend), .mii_crs_i(crs), .send_irq_o(irq), .tx_busy_o(busy),
    .rx_desc_addr_o(rxa), .rx_link_valid_o(rxv));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic summarize();
    $display("tests %0d fails %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : summarize
  task automatic pulse(ref logic s);
    s = 1;
    @(posedge clk_i);
    #1 s = 0;
    @(posedge clk_i);
    #1;
  endtask : pulse
  task automatic frame(input logic [31:0] d, input logic [2:0] ctl, input logic [15:0] len,
      input int ncol, input logic halt);
    logic [31:0] w0, a, ex;
    logic ab, hb, nce, exe;
    int tot, i, k, nc, i0;
    w0 = {1'b1, 28'(rnd()), ctl};
    nc = ncol;
    hd = w0[4] || nc == 16;
    ab = hd && nc == 16;
    {sfp, ffr, heartbeat_err, hbc, s10, dfr} = w0[10:5];
    crs = !(w0[11] && w0[12]);
    i0 = irqs;
    i = 0;
    tot = (ctl[0] && len < 60) ? 60 : len;
    // long frames always defer past both sim limits, short ones may not
    nwl = tot < 59;
    hb = hd && !ab && heartbeat_err && hbc && s10;
    nce = hd && !ab && !crs;
    exe = hd && dfr && tot >= 59;
    ex = {hd ? 4'(nc) : 4'h0, 1'b0, hb, sfp | ffr, halt, 1'b0, ab, nce, exe, !ab, 1'b0,
      hd && dfr, ctl[2], len};
    mem_u.mem[d[9:2] + 1] = 32'h0000_0201;
    mem_u.mem[d[9:2] + 2] = len;
    mem_u.mem[d[9:2] + 3] = d + 32'h0000_0010;
    mem_u.mem[d[9:2] + 4] = 32'h0000_0000;
    for (k = 0; k < 16; k++) mem_u.mem[8'h80 + k] = rnd();
    mem_u.mem[d[9:2]] = w0;
    pulse(kick);
    for (k = 0; k < 5000 && i < tot; k++) begin
      @(negedge clk_i);
      if (txv === 1'b1 && rdy === 1'b1) begin
        a = 32'h0000_0201 + i;
        if (i == 0) chk(fcs, ctl[1]);
        chk(txd, (i < len) ? 8'(mem_u.mem[a[9:2]] >> {a[1:0], 3'b000}) : 8'h00);
        chk(txl, i == tot - 1);
        i++;
      end
      @(posedge clk_i);
      #1 rdy = rnd() % 3 == 0;
    end
    chk(i, tot);
    run = !halt;
    for (k = 0; k < nc; k++) pulse(col);
    if (!ab) pulse(mend);
    for (k = 0; k < 300 && busy !== 1'b0; k++) begin
      @(posedge clk_i);
      #1;
    end
    chk(busy, 0);
    chk(mem_u.mem[d[9:2] + 2], ex);
    chk(mem_u.mem[d[9:2]], w0 & 32'h7FFF_FFFF);
    chk(irqs - i0, ctl[2]);
    $display("frame at %h done", d);
  endtask : frame
  logic [2:0] cc [0:2] = '{3'b111, 3'b000, 3'b001};
  logic [15:0] cl [0:2] = '{16'h0001, 16'h003B, 16'h003C};
  initial begin
    #3_000_000 n_fail++;
    summarize();
  end
  initial begin
    repeat (20) @(posedge clk_i);
    #1 nrst_i = 1;
    for (int t = 0; t < 7; t++) begin
      frame(32'h0000_0100 + 16 * t, t < 3 ? cc[t] : 3'(rnd()),
        t < 3 ? cl[t] : 16'(rnd() % 63 + 1), t == 3 ? 16 : int'(rnd() % 16), t == 6);
    end
    mem_u.mem[8'hC3] = 32'h0000_0313;
    pulse(rxn);
    repeat (4) @(posedge clk_i);
    #1 chk({rxv, rxa}, {1'b1, rb});
    pulse(rxn);
    for (int k = 0; k < 100 && rxa === rb; k++) @(posedge clk_i);
    chk(rxa, 32'h0000_0310);
    $display("rx link done");
    summarize();
  end
endmodule : mac_descriptor_handling_tb
